// *** aae_pkg.sv ***
package aae_pkg;
	// ----------------------------------------
	// register map (byte offsets)
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_ACC = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MADDR = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_MDATA = 8'h10;
	// ----------------------------------------
	// widths and field positions
	// ----------------------------------------
	localparam int IW = 14;
	localparam int DW = 8;
	localparam int FW = 7;
	localparam int TOP_HI = 13;
	localparam int TOP_LO = 12;
	localparam int OP_HI = 11;
	localparam int OP_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int F_HI = 6;
	localparam int K_HI = 7;
	localparam int NIB_HI = 3;
	localparam int C_OUT_BIT = 8;
	localparam int HC_OUT_BIT = 4;
	localparam int ST_C = 0;
	localparam int ST_HC = 1;
	localparam int ST_Z = 2;
	localparam int ST_BUSY = 3;
	// ----------------------------------------
	// encodings
	// ----------------------------------------
	localparam logic [1:0] TOP_BYTE_OPS = 2'h0;
	localparam logic [1:0] TOP_LIT_OPS = 2'h3;
	localparam logic [3:0] OP_ADD_REG = 4'h7;
	localparam logic [3:0] OP_AND_LIT = 4'h9;
	localparam logic [3:0] OP_AND_REG = 4'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [IW-1:0] INSTR_RST = 14'h0000;
	localparam logic [DW-1:0] ACC_RST = 8'h00;
	localparam logic [DW-1:0] ZERO_BYTE = 8'h00;
	localparam logic [FW-1:0] MADDR_RST = 7'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [4:0] {
		AAE_IDLE = 5'h01,
		AAE_DEC = 5'h02,
		AAE_READ = 5'h04,
		AAE_PROC = 5'h08,
		AAE_WRITE = 5'h10
	} aae_state_t;
	typedef enum logic [1:0] {
		AAE_K_NONE = 2'h0,
		AAE_K_ADD = 2'h1,
		AAE_K_ANDL = 2'h2,
		AAE_K_ANDR = 2'h3
	} aae_kind_t;
endpackage

// *** aae_regfile.sv ***
`timescale 1ns/1ps
module aae_regfile #(
	parameter int DEPTH_W = 7,
	parameter int DATA_W = 8
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic we,
	input wire logic [DEPTH_W-1:0] waddr,
	input wire logic [DATA_W-1:0] wdata,
	// read port, data one cycle after address
	input wire logic [DEPTH_W-1:0] raddr,
	output logic [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] mem [0:(1<<DEPTH_W)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// *** aae_core.sv ***
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module aae_core
	import aae_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	aae_state_t state_r, state_nxt;
	aae_kind_t kind_r, kind_nxt;
	logic [IW-1:0] instr_r, instr_nxt;
	logic [DW-1:0] acc_r, acc_nxt;
	logic c_r, c_nxt, hc_r, hc_nxt, z_r, z_nxt;
	logic [FW-1:0] maddr_r, maddr_nxt;
	logic [DW-1:0] res_r, res_nxt;
	logic rc_r, rc_nxt, rhc_r, rhc_nxt;
	logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, rwait_r, rwait_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic mem_we;
	logic [FW-1:0] mem_waddr, mem_raddr;
	logic [DW-1:0] mem_wdata, mem_q;

	aae_regfile #(.DEPTH_W(FW), .DATA_W(DW)) u_regfile (
		.clk(sys_clk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_q)
	);

	// ----------------------------------------
	// decoded fields
	// ----------------------------------------
	logic idle;
	logic dest_reg;
	logic [FW-1:0] f_addr;
	logic [DW-1:0] operand;
	logic [C_OUT_BIT:0] sum9;
	logic [HC_OUT_BIT:0] sum5;
	logic do_wr, do_rd;
	logic [ADDR_W-1:2] wsel, rsel;
	logic [DW-1:0] status_byte;

	assign idle = (state_r == AAE_IDLE);
	assign dest_reg = instr_r[DEST_BIT];
	assign f_addr = instr_r[F_HI:0];
	assign status_byte = {4'h0, ~idle, z_r, hc_r, c_r};
	assign do_wr = aw_hold_r && w_hold_r && !bvalid_r && idle;
	assign do_rd = s_axi_arvalid && s_axi_arready;
	assign wsel = awaddr_r[ADDR_W-1:2];
	assign rsel = s_axi_araddr[ADDR_W-1:2];
	assign operand = (kind_r == AAE_K_ANDL) ? instr_r[K_HI:0] : mem_q;
	assign sum9 = {1'b0, acc_r} + {1'b0, operand};
	assign sum5 = {1'b0, acc_r[NIB_HI:0]} + {1'b0, operand[NIB_HI:0]};

	// ----------------------------------------
	// register file ports
	// ----------------------------------------
	assign mem_raddr = idle ? maddr_r : f_addr;
	assign mem_we = (do_wr && wsel == OFF_MDATA[ADDR_W-1:2] && wstrb_r[0])
		|| (state_r == AAE_WRITE && dest_reg && kind_r != AAE_K_NONE && kind_r != AAE_K_ANDL);
	assign mem_waddr = idle ? maddr_r : f_addr;
	assign mem_wdata = idle ? wdata_r[DW-1:0] : res_r;

	// ----------------------------------------
	// bus handshakes
	// ----------------------------------------
	assign s_axi_awready = !aw_hold_r;
	assign s_axi_wready = !w_hold_r;
	assign s_axi_arready = !rvalid_r && !rwait_r && idle;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		instr_nxt = instr_r;
		acc_nxt = acc_r;
		c_nxt = c_r;
		hc_nxt = hc_r;
		z_nxt = z_r;
		maddr_nxt = maddr_r;
		res_nxt = res_r;
		rc_nxt = rc_r;
		rhc_nxt = rhc_r;
		aw_hold_nxt = aw_hold_r;
		awaddr_nxt = awaddr_r;
		w_hold_nxt = w_hold_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rwait_nxt = rwait_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;

		// instruction sequencer, one phase per clock
		case (state_r)
			AAE_IDLE: begin
			end
			AAE_DEC: begin
				kind_nxt = AAE_K_NONE;
				if (instr_r[TOP_HI:TOP_LO] == TOP_BYTE_OPS && instr_r[OP_HI:OP_LO] == OP_ADD_REG) begin
					kind_nxt = AAE_K_ADD;
				end
				if (instr_r[TOP_HI:TOP_LO] == TOP_BYTE_OPS && instr_r[OP_HI:OP_LO] == OP_AND_REG) begin
					kind_nxt = AAE_K_ANDR;
				end
				if (instr_r[TOP_HI:TOP_LO] == TOP_LIT_OPS && instr_r[OP_HI:OP_LO] == OP_AND_LIT) begin
					kind_nxt = AAE_K_ANDL;
				end
				state_nxt = AAE_READ;
			end
			AAE_READ: begin
				state_nxt = AAE_PROC;
			end
			AAE_PROC: begin
				if (kind_r == AAE_K_ADD) begin
					res_nxt = sum9[DW-1:0];
				end else begin
					res_nxt = acc_r & operand;
				end
				rc_nxt = sum9[C_OUT_BIT];
				rhc_nxt = sum5[HC_OUT_BIT];
				state_nxt = AAE_WRITE;
			end
			AAE_WRITE: begin
				if (kind_r != AAE_K_NONE) begin
					z_nxt = (res_r == ZERO_BYTE);
					if (kind_r == AAE_K_ADD) begin
						c_nxt = rc_r;
						hc_nxt = rhc_r;
					end
					// and-type results keep carry flags
					if (kind_r == AAE_K_ANDL || !dest_reg) begin
						acc_nxt = res_r;
					end
				end
				state_nxt = AAE_IDLE;
			end
			default: begin
				state_nxt = AAE_IDLE;
			end
		endcase

		// write channel capture
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end

		// register write, only between instructions
		if (do_wr) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			if (awaddr_r[1:0] != 2'h0 || awaddr_r > OFF_MDATA) begin
				bresp_nxt = RESP_SLVERR;
			end else begin
				case (wsel)
					OFF_INSTR[ADDR_W-1:2]: begin
						if (wstrb_r[0]) begin
							instr_nxt[DW-1:0] = wdata_r[DW-1:0];
						end
						if (wstrb_r[1]) begin
							instr_nxt[IW-1:DW] = wdata_r[IW-1:DW];
						end
						state_nxt = AAE_DEC;
					end
					OFF_ACC[ADDR_W-1:2]: begin
						if (wstrb_r[0]) begin
							acc_nxt = wdata_r[DW-1:0];
						end
					end
					OFF_STATUS[ADDR_W-1:2]: begin
						if (wstrb_r[0]) begin
							c_nxt = wdata_r[ST_C];
							hc_nxt = wdata_r[ST_HC];
							z_nxt = wdata_r[ST_Z];
						end
					end
					OFF_MADDR[ADDR_W-1:2]: begin
						if (wstrb_r[0]) begin
							maddr_nxt = wdata_r[FW-1:0];
						end
					end
					default: begin
					end
				endcase
			end
		end

		// read channel
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (rwait_r) begin
			rwait_nxt = 1'b0;
			rvalid_nxt = 1'b1;
			rdata_nxt = {24'h00_0000, mem_q};
		end
		if (do_rd) begin
			rresp_nxt = RESP_OKAY;
			rdata_nxt = WORD_ZERO;
			rvalid_nxt = 1'b1;
			if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > OFF_MDATA) begin
				rresp_nxt = RESP_SLVERR;
			end else begin
				case (rsel)
					OFF_INSTR[ADDR_W-1:2]: rdata_nxt = {18'h0_0000, instr_r};
					OFF_ACC[ADDR_W-1:2]: rdata_nxt = {24'h00_0000, acc_r};
					OFF_STATUS[ADDR_W-1:2]: rdata_nxt = {24'h00_0000, status_byte};
					OFF_MADDR[ADDR_W-1:2]: rdata_nxt = {25'h000_0000, maddr_r};
					OFF_MDATA[ADDR_W-1:2]: begin
						rvalid_nxt = 1'b0;
						rwait_nxt = 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_r <= AAE_IDLE;
			kind_r <= AAE_K_NONE;
			instr_r <= INSTR_RST;
			acc_r <= ACC_RST;
			c_r <= 1'b0;
			hc_r <= 1'b0;
			z_r <= 1'b0;
			maddr_r <= MADDR_RST;
			res_r <= ZERO_BYTE;
			rc_r <= 1'b0;
			rhc_r <= 1'b0;
			aw_hold_r <= 1'b0;
			awaddr_r <= OFF_INSTR;
			w_hold_r <= 1'b0;
			wdata_r <= WORD_ZERO;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rwait_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= WORD_ZERO;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			instr_r <= instr_nxt;
			acc_r <= acc_nxt;
			c_r <= c_nxt;
			hc_r <= hc_nxt;
			z_r <= z_nxt;
			maddr_r <= maddr_nxt;
			res_r <= res_nxt;
			rc_r <= rc_nxt;
			rhc_r <= rhc_nxt;
			aw_hold_r <= aw_hold_nxt;
			awaddr_r <= awaddr_nxt;
			w_hold_r <= w_hold_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rwait_r <= rwait_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end
endmodule

// *** aae_core_asserts.sv ***
`timescale 1ns/1ps
module aae_core_chk
	import aae_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// write side
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	// read side
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid
);
	logic ins_r;
	logic bad_aw;
	logic bad_ar;
	assign bad_aw = (s_axi_awaddr > OFF_MDATA) || (s_axi_awaddr[1:0] != 2'h0);
	assign bad_ar = (s_axi_araddr > OFF_MDATA) || (s_axi_araddr[1:0] != 2'h0);
	// last accepted write went to the instruction register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ins_r <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			ins_r <= (s_axi_awaddr == OFF_INSTR);
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence aw_take;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_write_answer: assert property (aw_take ##0 (s_axi_wvalid && s_axi_wready) |-> ##[1:8] s_axi_bvalid)
		else $error("write not answered");
	chk_write_error: assert property (aw_take ##0 bad_aw |-> ##[1:8] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
		else $error("bad write address not refused");
	chk_write_okay: assert property (aw_take ##0 !bad_aw |-> ##[1:8] (s_axi_bvalid && s_axi_bresp == RESP_OKAY))
		else $error("good write not okay");
	chk_read_error: assert property (ar_take ##0 bad_ar |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR
		&& s_axi_rdata == WORD_ZERO)
		else $error("bad read address not refused");
	chk_read_fast: assert property (ar_take ##0 (s_axi_araddr == OFF_ACC || s_axi_araddr == OFF_STATUS)
		|=> s_axi_rvalid && s_axi_rresp == RESP_OKAY)
		else $error("register read late");
	chk_mdata_wait: assert property (ar_take ##0 (s_axi_araddr == OFF_MDATA) |=> !s_axi_rvalid ##1 s_axi_rvalid)
		else $error("data register read timing wrong");
	chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	chk_exec_stall: assert property ($rose(s_axi_bvalid) && ins_r |-> !s_axi_arready [*4] ##1 s_axi_arready)
		else $error("execution not four cycles");
endmodule

bind aae_core aae_core_chk u_chk (.*);

// *** aae_core_tb.sv ***
`timescale 1ns/1ps
`define CMP(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module aae_core_tb_top
	import aae_pkg::*;
;
	typedef struct packed {
		logic [7:0] acc, mem, st;
		logic [6:0] f;
		logic [13:0] ins;
		logic [7:0] eacc, emem, est;
	} aae_row_t;
	logic sys_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, last_b, rd_r;
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	// acc, mem, status, f, word, then expected acc, mem, status
	aae_row_t rows [9] = '{
		'{8'h17, 8'hC2, 8'h00, 7'h05, 14'h0705, 8'hD9, 8'hC2, 8'h00},
		'{8'h88, 8'h78, 8'h00, 7'h7F, 14'h07FF, 8'h88, 8'h00, 8'h07},
		'{8'h0F, 8'h01, 8'h04, 7'h02, 14'h0702, 8'h10, 8'h01, 8'h02},
		'{8'hA3, 8'hC2, 8'h03, 7'h05, 14'h395F, 8'h03, 8'hC2, 8'h03},
		'{8'hF0, 8'h11, 8'h00, 7'h05, 14'h390F, 8'h00, 8'h11, 8'h04},
		'{8'hFF, 8'h00, 8'h07, 7'h10, 14'h39FF, 8'hFF, 8'h00, 8'h03},
		'{8'h17, 8'hC2, 8'h03, 7'h00, 14'h0580, 8'h17, 8'h02, 8'h03},
		'{8'h0F, 8'hF0, 8'h00, 7'h01, 14'h0501, 8'h00, 8'hF0, 8'h04},
		'{8'h55, 8'hAA, 8'h05, 7'h03, 14'h3E03, 8'h55, 8'hAA, 8'h05}
	};
	aae_core dut (.*);
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		last_b = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CMP(rd_d, e)
		`CMP(rd_r, RESP_OKAY)
	endtask
	task automatic wrap_up();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			wr(OFF_ACC, 32'(rows[i].acc));
			wr(OFF_STATUS, 32'(rows[i].st));
			wr(OFF_MADDR, 32'(rows[i].f));
			wr(OFF_MDATA, 32'(rows[i].mem));
			wr(OFF_INSTR, 32'(rows[i].ins));
			chk_rd(OFF_ACC, 32'(rows[i].eacc));
			chk_rd(OFF_MDATA, 32'(rows[i].emem));
			chk_rd(OFF_STATUS, 32'(rows[i].est));
			$display("row %0d done", i);
		end
		// back-to-back adds, second waits for the first
		wr(OFF_ACC, 32'h0000_0001);
		wr(OFF_MADDR, 32'h0000_0000);
		wr(OFF_MDATA, 32'h0000_0001);
		wr(OFF_INSTR, 32'h0000_0700);
		wr(OFF_INSTR, 32'h0000_0700);
		chk_rd(OFF_ACC, 32'h0000_0003);
		$display("back to back done");
		// second reset in mid-run
		reset <= 1'b1;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		chk_rd(OFF_INSTR, 32'h0000_0000);
		chk_rd(OFF_ACC, 32'h0000_0000);
		chk_rd(OFF_STATUS, 32'h0000_0000);
		chk_rd(OFF_MADDR, 32'h0000_0000);
		$display("reset done");
		// refused addresses
		wr(8'h14, 32'h0000_0077);
		`CMP(last_b, RESP_SLVERR)
		wr(8'h05, 32'h0000_0077);
		`CMP(last_b, RESP_SLVERR)
		rd(8'h14);
		`CMP(rd_r, RESP_SLVERR)
		`CMP(rd_d, WORD_ZERO)
		chk_rd(OFF_ACC, 32'h0000_0000);
		$display("error done");
		// low lane off: accumulator must keep its value
		s_axi_wstrb <= 4'h2;
		wr(OFF_ACC, 32'h0000_00AA);
		s_axi_wstrb <= 4'hF;
		`CMP(last_b, RESP_OKAY)
		chk_rd(OFF_ACC, 32'h0000_0000);
		$display("strobe done");
		wrap_up();
	end
endmodule
